// >>> hdl/host_link.sv
`timescale 1ns/1ps
// Overview of operation
// - host software keeps every panel word current
// - panel sends touch data; host writes back
// - panel priority: panel wins, host waits
// - host priority: host wins, panel waits
// - double word uses two words, even address
// - STX opens; answer ACK ready, NAK busy (the host only ever answers ACK; when busy it sends no NAK)
// - after frame, ACK good, NAK bad
// - on NAK, wait and repeat sequence
// - word frame: 01, addr, count, data, trailer
// - no read command; writes only
// - data byte 10 hex sent twice
// - check byte XORs all bytes, DLE, ETX
// - parity, 7/8 data, 1/2 stop selectable
module host_link #(
	parameter int UNIT_CYC = host_pkg::UNIT_CYC,
	parameter int REPLY_CYC = host_pkg::REPLY_CYC,
	parameter int BACKOFF_CYC = host_pkg::BACKOFF_CYC,
	// a nonzero shift shortens every bit time, for quick runs
	parameter int DIV_SHIFT = 0
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        nrst,
	// register port
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	// serial link
	output logic             txd,
	output logic             txd_oe,
	input  wire logic        rxd
);
	import host_pkg::*;

	state_t           st_r;
	logic [31:0]      tmr_r;
	logic [9:0]       units_r;
	logic [3:0]       idx_r;
	logic             dup_r;
	logic [7:0]       bcc_r;
	logic [3:0]       tries_r;
	logic             go_r;
	logic [7:0]       txb_r;
	logic             ev_done_r;
	logic             ev_fail_r;
	logic             ev_rxok_r;
	logic             ev_rxbad_r;
	logic             rdle_r;
	logic             retx_r;
	logic             rerr_r;
	logic [7:0]       rbcc_r;
	logic             rok_r;
	logic [3:0]       ridx_r;
	logic             panel_r;
	logic             bitw_r;
	logic             dbl_r;
	logic [15:0]      addr_r;
	logic [15:0]      d0_r;
	logic [15:0]      d1_r;
	logic [6:0]       cfg_r;
	logic [9:0]       gap_r;
	logic             pend_r;
	logic             done_r;
	logic             fail_r;
	logic             rxnew_r;
	logic             rxbad_r;
	logic [7:0]       rx_cmd_r;
	logic [15:0]      rx_addr_r;
	logic [7:0]       rx_cnt_r;
	logic [15:0]      rx_d0_r;
	logic [15:0]      rx_d1_r;
	logic [DIV_W-1:0] div;
	logic             tx_busy;
	logic             rx_valid;
	logic [7:0]       rx_byte;
	logic             rx_bad;
	logic             rx_busy;
	logic             tx_rdy;
	logic             rx_ok;
	logic             rx_stx;
	logic             rx_ack;
	logic             rx_nak;
	logic             reply_tmo;
	logic             give_up;
	logic             rx_store;
	logic [7:0]       n_data;
	logic [3:0]       dend;
	logic [7:0]       cur_b;
	logic             esc;
	logic             go_wr;
	logic             go_bad;

	serial_char #(
		.DIV_W    (DIV_W)
	) u_char (
		.clk      (clk),
		.nrst     (nrst),
		.div      (div),
		.seven    (cfg_r[CFG_SEVEN]),
		.par      (cfg_r[CFG_PAR+:2]),
		.two_stop (cfg_r[CFG_TWO]),
		.tx_go    (go_r),
		.tx_byte  (txb_r),
		.tx_busy  (tx_busy),
		.txd      (txd),
		.txd_oe   (txd_oe),
		.rxd      (rxd),
		.rx_valid (rx_valid),
		.rx_byte  (rx_byte),
		.rx_bad   (rx_bad),
		.rx_busy  (rx_busy)
	);

	always_comb
	begin
		unique case (cfg_r[CFG_BAUD+:3])
			3'h1: div = DIV_19200 >> DIV_SHIFT;
			3'h2: div = DIV_38400 >> DIV_SHIFT;
			3'h3: div = DIV_57600 >> DIV_SHIFT;
			3'h4: div = DIV_115200 >> DIV_SHIFT;
			default: div = DIV_9600 >> DIV_SHIFT;
		endcase
	end

	// busy goes high the cycle after go, so go itself blocks a second byte
	assign tx_rdy = !tx_busy && !go_r;
	assign rx_ok = rx_valid && !rx_bad;
	assign rx_stx = rx_ok && rx_byte == CH_STX;
	assign rx_ack = rx_ok && rx_byte == CH_ACK;
	assign rx_nak = rx_valid && !rx_ack;
	assign reply_tmo = tmr_r == 32'(REPLY_CYC - 1);
	assign give_up = tries_r == MAX_TRIES - 4'd1;

	// outgoing frame laid out by byte index
	always_comb
	begin
		n_data = dbl_r ? 8'd4 : (bitw_r ? 8'd1 : 8'd2);
		dend = 4'd4 + n_data[3:0];
		cur_b = bcc_r;
		unique case (idx_r)
			4'd0: cur_b = bitw_r ? CMD_BIT : CMD_WORD;
			4'd1: cur_b = addr_r[7:0];
			4'd2: cur_b = addr_r[15:8];
			4'd3: cur_b = n_data;
			4'd4: cur_b = bitw_r ? {7'd0, d0_r[0]} : d0_r[7:0];
			4'd5: cur_b = d0_r[15:8];
			4'd6: cur_b = d1_r[7:0];
			4'd7: cur_b = d1_r[15:8];
			default: cur_b = bcc_r;
		endcase
		if (idx_r == dend)
			cur_b = CH_DLE;
		else if (idx_r == dend + 4'd1)
			cur_b = CH_ETX;
		else if (idx_r == dend + 4'd2)
			cur_b = bcc_r;
		esc = idx_r < dend && cur_b == CH_DLE;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_r <= S_IDLE;
			tmr_r <= 32'd0;
			units_r <= 10'd0;
			idx_r <= 4'd0;
			dup_r <= 1'b0;
			bcc_r <= 8'h00;
			tries_r <= 4'd0;
			go_r <= 1'b0;
			txb_r <= 8'h00;
			ev_done_r <= 1'b0;
			ev_fail_r <= 1'b0;
			ev_rxok_r <= 1'b0;
			ev_rxbad_r <= 1'b0;
			rdle_r <= 1'b0;
			retx_r <= 1'b0;
			rerr_r <= 1'b0;
			rbcc_r <= 8'h00;
			rok_r <= 1'b0;
		end
		else
		begin
			go_r <= 1'b0;
			ev_done_r <= 1'b0;
			ev_fail_r <= 1'b0;
			ev_rxok_r <= 1'b0;
			ev_rxbad_r <= 1'b0;
			tmr_r <= tmr_r + 32'd1;
			unique case (st_r)
				S_IDLE:
				begin
					tmr_r <= 32'd0;
					units_r <= 10'd0;
					if (rx_stx)
						st_r <= S_RACK;
					else if (pend_r && !rx_busy)
						st_r <= S_GAP;
				end
				S_GAP:
				begin
					if (rx_stx)
						st_r <= S_RACK;
					else if (units_r >= gap_r && !rx_busy)
					begin
						go_r <= 1'b1;
						txb_r <= CH_STX;
						tmr_r <= 32'd0;
						st_r <= S_WREPLY;
					end
					else if (tmr_r == 32'(UNIT_CYC - 1))
					begin
						tmr_r <= 32'd0;
						units_r <= units_r + 10'd1;
					end
				end
				S_WREPLY:
				begin
					if (rx_ack)
					begin
						idx_r <= 4'd0;
						dup_r <= 1'b0;
						bcc_r <= 8'h00;
						st_r <= S_BODY;
					end
					else if (rx_stx && panel_r)
						st_r <= S_RACK;
					// in host priority a crossing STX is ignored
					else if ((rx_nak && !rx_stx) || reply_tmo)
					begin
						tmr_r <= 32'd0;
						tries_r <= give_up ? 4'd0 : tries_r + 4'd1;
						ev_fail_r <= give_up;
						st_r <= give_up ? S_IDLE : S_BACKOFF;
					end
				end
				S_BODY:
				begin
					if (tx_rdy)
					begin
						go_r <= 1'b1;
						txb_r <= cur_b;
						bcc_r <= bcc_r ^ cur_b;
						if (esc && !dup_r)
							dup_r <= 1'b1;
						else
						begin
							dup_r <= 1'b0;
							idx_r <= idx_r + 4'd1;
							if (idx_r == dend + 4'd2)
							begin
								tmr_r <= 32'd0;
								st_r <= S_WFINAL;
							end
						end
					end
				end
				S_WFINAL:
				begin
					if (rx_ack)
					begin
						tries_r <= 4'd0;
						ev_done_r <= 1'b1;
						st_r <= S_IDLE;
					end
					else if (rx_valid || reply_tmo)
					begin
						tmr_r <= 32'd0;
						tries_r <= give_up ? 4'd0 : tries_r + 4'd1;
						ev_fail_r <= give_up;
						st_r <= give_up ? S_IDLE : S_BACKOFF;
					end
				end
				S_BACKOFF:
				begin
					if (rx_stx)
						st_r <= S_RACK;
					else if (tmr_r == 32'(BACKOFF_CYC - 1))
					begin
						tmr_r <= 32'd0;
						units_r <= 10'd0;
						st_r <= S_GAP;
					end
				end
				S_RACK:
				begin
					tmr_r <= 32'd0;
					rdle_r <= 1'b0;
					retx_r <= 1'b0;
					rerr_r <= 1'b0;
					rbcc_r <= 8'h00;
					if (tx_rdy)
					begin
						go_r <= 1'b1;
						txb_r <= CH_ACK;
						st_r <= S_RBODY;
					end
				end
				S_RBODY:
				begin
					if (reply_tmo)
					begin
						ev_rxbad_r <= 1'b1;
						st_r <= S_IDLE;
					end
					else if (rx_valid)
					begin
						tmr_r <= 32'd0;
						rbcc_r <= rbcc_r ^ rx_byte;
						if (rx_bad)
							rerr_r <= 1'b1;
						if (retx_r)
						begin
							rok_r <= !rerr_r && !rx_bad
								&& rx_byte == rbcc_r
								&& (rx_cmd_r == CMD_WORD
								|| rx_cmd_r == CMD_BIT);
							st_r <= S_RREPLY;
						end
						else if (rdle_r)
						begin
							rdle_r <= 1'b0;
							if (rx_byte == CH_ETX)
								retx_r <= 1'b1;
							else if (rx_byte != CH_DLE)
								rerr_r <= 1'b1;
						end
						else if (rx_byte == CH_DLE)
							rdle_r <= 1'b1;
					end
				end
				S_RREPLY:
				begin
					if (tx_rdy)
					begin
						go_r <= 1'b1;
						txb_r <= rok_r ? CH_ACK : CH_NAK;
						ev_rxok_r <= rok_r;
						ev_rxbad_r <= !rok_r;
						st_r <= S_IDLE;
					end
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end

	// a doubled DLE stores once; a lone DLE only opens the trailer
	assign rx_store = st_r == S_RBODY && rx_valid && !retx_r && !reply_tmo
		&& (rdle_r ? rx_byte == CH_DLE : rx_byte != CH_DLE);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ridx_r <= 4'd0;
			rx_cmd_r <= 8'h00;
			rx_addr_r <= 16'h0000;
			rx_cnt_r <= 8'h00;
			rx_d0_r <= 16'h0000;
			rx_d1_r <= 16'h0000;
		end
		else if (st_r == S_RACK)
			ridx_r <= 4'd0;
		else if (rx_store)
		begin
			if (ridx_r != 4'hF)
				ridx_r <= ridx_r + 4'd1;
			unique case (ridx_r)
				4'd0: rx_cmd_r <= rx_byte;
				4'd1: rx_addr_r[7:0] <= rx_byte;
				4'd2: rx_addr_r[15:8] <= rx_byte;
				4'd3: rx_cnt_r <= rx_byte;
				4'd4: rx_d0_r[7:0] <= rx_byte;
				4'd5: rx_d0_r[15:8] <= rx_byte;
				4'd6: rx_d1_r[7:0] <= rx_byte;
				4'd7: rx_d1_r[15:8] <= rx_byte;
				default: ;
			endcase
		end
	end

	// the host checks target addresses itself; only a bit write with DBL
	// also set still goes out with count 4, which the panel must refuse
	assign go_wr = wr && addr == REG_CTRL && wdata[CTRL_GO] && !pend_r;
	assign go_bad = wdata[CTRL_BITW] ? addr_r >= BIT_LIM
		: wdata[CTRL_DBL] ? (addr_r[0] || addr_r >= WORD_LIM - 16'd1)
		: addr_r >= WORD_LIM;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			panel_r <= 1'b0;
			bitw_r <= 1'b0;
			dbl_r <= 1'b0;
			addr_r <= 16'h0000;
			d0_r <= 16'h0000;
			d1_r <= 16'h0000;
			cfg_r <= CFG_RST;
			gap_r <= 10'd0;
		end
		else if (wr && !pend_r)
		begin
			unique case (addr)
				REG_CTRL:
				begin
					panel_r <= wdata[CTRL_PANEL];
					bitw_r <= wdata[CTRL_BITW];
					dbl_r <= wdata[CTRL_DBL];
				end
				REG_ADDR: addr_r <= wdata;
				REG_DATA0: d0_r <= wdata;
				REG_DATA1: d1_r <= wdata;
				REG_CFG: cfg_r <= wdata[6:0];
				REG_GAP: gap_r <= wdata > 16'(GAP_MAX) ? GAP_MAX
					: wdata[9:0];
				default: ;
			endcase
		end
	end

	// hardware events win over a software clear in the same cycle
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pend_r <= 1'b0;
			done_r <= 1'b0;
			fail_r <= 1'b0;
			rxnew_r <= 1'b0;
			rxbad_r <= 1'b0;
		end
		else
		begin
			if (go_wr && !go_bad)
				pend_r <= 1'b1;
			else if (ev_done_r || ev_fail_r)
				pend_r <= 1'b0;
			if (ev_done_r)
				done_r <= 1'b1;
			else if (wr && addr == REG_STAT && wdata[ST_DONE])
				done_r <= 1'b0;
			if (ev_fail_r || (go_wr && go_bad))
				fail_r <= 1'b1;
			else if (wr && addr == REG_STAT && wdata[ST_FAIL])
				fail_r <= 1'b0;
			if (ev_rxok_r)
				rxnew_r <= 1'b1;
			else if (wr && addr == REG_STAT && wdata[ST_RXNEW])
				rxnew_r <= 1'b0;
			if (ev_rxbad_r)
				rxbad_r <= 1'b1;
			else if (wr && addr == REG_STAT && wdata[ST_RXBAD])
				rxbad_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rdata <= 16'h0000;
		else if (!rd)
			rdata <= 16'h0000;
		else
		begin
			unique case (addr)
				REG_CTRL: rdata <= {12'h000, panel_r, dbl_r, bitw_r,
					pend_r};
				REG_ADDR: rdata <= addr_r;
				REG_DATA0: rdata <= d0_r;
				REG_DATA1: rdata <= d1_r;
				REG_CFG: rdata <= {9'h000, cfg_r};
				REG_GAP: rdata <= {6'h00, gap_r};
				REG_STAT: rdata <= {11'h000, rxbad_r, rxnew_r, fail_r,
					done_r, pend_r || st_r != S_IDLE};
				REG_RXADDR: rdata <= rx_addr_r;
				REG_RXD0: rdata <= rx_d0_r;
				REG_RXD1: rdata <= rx_d1_r;
				REG_RXINFO: rdata <= {rx_cnt_r, rx_cmd_r};
				default: rdata <= 16'h0000;
			endcase
		end
	end
endmodule

// >>> hdl/serial_char.sv
`timescale 1ns/1ps
module serial_char #(
	parameter int DIV_W = 16
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// character format
	input  wire logic [DIV_W-1:0] div,
	input  wire logic             seven,
	input  wire logic [1:0]       par,
	input  wire logic             two_stop,
	// transmit
	input  wire logic             tx_go,
	input  wire logic [7:0]       tx_byte,
	output logic                  tx_busy,
	output logic                  txd,
	output logic                  txd_oe,
	// receive
	input  wire logic             rxd,
	output logic                  rx_valid,
	output logic [7:0]            rx_byte,
	output logic                  rx_bad,
	output logic                  rx_busy
);
	import host_pkg::*;

	logic [11:0]      tx_sh_r;
	logic [3:0]       tx_left_r;
	logic [DIV_W-1:0] tx_cnt_r;
	logic [7:0]       tx_d;
	logic [11:0]      tx_frame;
	logic [3:0]       tx_len;
	logic             rx_s1_r;
	logic             rx_s2_r;
	logic [DIV_W-1:0] rx_cnt_r;
	logic [3:0]       rx_pos_r;
	logic [11:0]      rx_v_r;
	logic             rx_fin_r;
	logic [3:0]       rx_last;
	logic [7:0]       rx_d;
	logic             rx_pb;

	always_comb
	begin
		tx_d = seven ? {1'b0, tx_byte[6:0]} : tx_byte;
		tx_frame = '1;
		tx_frame[0] = 1'b0;
		if (seven)
		begin
			tx_frame[7:1] = tx_d[6:0];
			if (par != PAR_NONE)
				tx_frame[8] = (par == PAR_ODD) ? ~^tx_d : ^tx_d;
		end
		else
		begin
			tx_frame[8:1] = tx_d;
			if (par != PAR_NONE)
				tx_frame[9] = (par == PAR_ODD) ? ~^tx_d : ^tx_d;
		end
		tx_len = 4'd10 - {3'd0, seven} + {3'd0, par != PAR_NONE}
			+ {3'd0, two_stop};
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_sh_r <= '1;
			tx_left_r <= 4'h0;
			tx_cnt_r <= '0;
			txd <= 1'b1;
			tx_busy <= 1'b0;
			txd_oe <= 1'b0;
		end
		else if (tx_go && !tx_busy)
		begin
			tx_sh_r <= tx_frame;
			tx_left_r <= tx_len;
			tx_cnt_r <= div - 1'b1;
			txd <= tx_frame[0];
			tx_busy <= 1'b1;
			txd_oe <= 1'b1;
		end
		else if (tx_busy)
		begin
			if (tx_cnt_r != '0)
				tx_cnt_r <= tx_cnt_r - 1'b1;
			else
			begin
				tx_cnt_r <= div - 1'b1;
				tx_sh_r <= {1'b1, tx_sh_r[11:1]};
				txd <= tx_sh_r[1];
				tx_left_r <= tx_left_r - 4'd1;
				if (tx_left_r == 4'd1)
				begin
					tx_busy <= 1'b0;
					txd_oe <= 1'b0;
					txd <= 1'b1;
				end
			end
		end
	end

	// position of the first stop bit; a second stop bit is not checked
	assign rx_last = 4'd9 - {3'd0, seven} + {3'd0, par != PAR_NONE};

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
		end
		else
		begin
			rx_s1_r <= rxd;
			rx_s2_r <= rx_s1_r;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_busy <= 1'b0;
			rx_cnt_r <= '0;
			rx_pos_r <= 4'h0;
			rx_v_r <= '0;
			rx_fin_r <= 1'b0;
		end
		else
		begin
			rx_fin_r <= 1'b0;
			if (!rx_busy)
			begin
				if (!rx_s2_r)
				begin
					rx_busy <= 1'b1;
					rx_cnt_r <= div >> 1;
					rx_pos_r <= 4'h0;
				end
			end
			else if (rx_cnt_r != '0)
				rx_cnt_r <= rx_cnt_r - 1'b1;
			else
			begin
				rx_cnt_r <= div - 1'b1;
				rx_v_r[rx_pos_r] <= rx_s2_r;
				rx_pos_r <= rx_pos_r + 4'd1;
				// a glitch that is high mid start bit is no character
				if (rx_pos_r == 4'h0 && rx_s2_r)
					rx_busy <= 1'b0;
				if (rx_pos_r == rx_last)
				begin
					rx_busy <= 1'b0;
					rx_fin_r <= 1'b1;
				end
			end
		end
	end

	always_comb
	begin
		rx_d = seven ? {1'b0, rx_v_r[7:1]} : rx_v_r[8:1];
		rx_pb = seven ? rx_v_r[8] : rx_v_r[9];
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rx_valid <= 1'b0;
			rx_byte <= 8'h00;
			rx_bad <= 1'b0;
		end
		else
		begin
			rx_valid <= rx_fin_r;
			if (rx_fin_r)
			begin
				rx_byte <= rx_d;
				rx_bad <= !rx_v_r[rx_last] || (par != PAR_NONE
					&& ((^rx_d ^ rx_pb) != (par == PAR_ODD)));
			end
		end
	end
endmodule

// >>> pkg/host_pkg.sv
package host_pkg;
	localparam int CLK_HZ = 200_000_000;
	localparam int CLK_KHZ = CLK_HZ / 1000;

	// control characters on the link
	localparam logic [7:0] CH_STX = 8'h02;
	localparam logic [7:0] CH_ETX = 8'h03;
	localparam logic [7:0] CH_ACK = 8'h06;
	localparam logic [7:0] CH_DLE = 8'h10;
	localparam logic [7:0] CH_NAK = 8'h15;
	localparam logic [7:0] CMD_WORD = 8'h01;
	localparam logic [7:0] CMD_BIT = 8'h02;

	// panel memory limits
	localparam logic [15:0] WORD_LIM = 16'h0200;
	localparam logic [15:0] BIT_LIM = 16'h1000;

	// line rates and their bit times in cycles
	localparam int DIV_W = 16;
	localparam logic [DIV_W-1:0] DIV_9600 = DIV_W'(CLK_HZ / 9600);
	localparam logic [DIV_W-1:0] DIV_19200 = DIV_W'(CLK_HZ / 19200);
	localparam logic [DIV_W-1:0] DIV_38400 = DIV_W'(CLK_HZ / 38400);
	localparam logic [DIV_W-1:0] DIV_57600 = DIV_W'(CLK_HZ / 57600);
	localparam logic [DIV_W-1:0] DIV_115200 = DIV_W'(CLK_HZ / 115200);

	// times in ms and their cycle counts
	localparam int UNIT_MS = 10;
	localparam int UNIT_CYC = CLK_KHZ * UNIT_MS;
	localparam int REPLY_MS = 100;
	localparam int REPLY_CYC = CLK_KHZ * REPLY_MS;
	localparam int BACKOFF_MS = 20;
	localparam int BACKOFF_CYC = CLK_KHZ * BACKOFF_MS;
	localparam logic [9:0] GAP_MAX = 10'd999;
	localparam logic [3:0] MAX_TRIES = 4'd8;

	// register offsets
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_DATA0 = 4'h2;
	localparam logic [3:0] REG_DATA1 = 4'h3;
	localparam logic [3:0] REG_CFG = 4'h4;
	localparam logic [3:0] REG_GAP = 4'h5;
	localparam logic [3:0] REG_STAT = 4'h6;
	localparam logic [3:0] REG_RXADDR = 4'h7;
	localparam logic [3:0] REG_RXD0 = 4'h8;
	localparam logic [3:0] REG_RXD1 = 4'h9;
	localparam logic [3:0] REG_RXINFO = 4'hA;

	// field positions
	localparam int CTRL_GO = 0;
	localparam int CTRL_BITW = 1;
	localparam int CTRL_DBL = 2;
	localparam int CTRL_PANEL = 3;
	localparam int CFG_BAUD = 0;
	localparam int CFG_PAR = 3;
	localparam int CFG_SEVEN = 5;
	localparam int CFG_TWO = 6;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_RXNEW = 3;
	localparam int ST_RXBAD = 4;

	// reset values: 9600 baud, odd parity, 8 data, 1 stop, no gap
	localparam logic [6:0] CFG_RST = 7'h08;
	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_ODD = 2'h1;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_GAP = 4'h1,
		S_WREPLY = 4'h3,
		S_BODY = 4'h2,
		S_WFINAL = 4'h6,
		S_BACKOFF = 4'h7,
		S_RACK = 4'h5,
		S_RBODY = 4'h4,
		S_RREPLY = 4'hC
	} state_t;
endpackage

// >>> testbench/host_link_props.sv
`timescale 1ns/1ps
module host_link_props #(
	parameter int DIV_SHIFT = 0
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        nrst,
	// register port
	input wire logic [3:0]  addr,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	// serial link
	input wire logic        txd,
	input wire logic        txd_oe
);
	import host_pkg::*;
	// fastest rate gives the shortest bit; 9 bits is the shortest character
	localparam int BIT_MIN = int'(DIV_115200 >> DIV_SHIFT) - 1;
	localparam int CHAR_MIN = 9 * (BIT_MIN + 1);
	int   oe_len;
	int   run;
	logic txd_q;
	logic cfg_seen;

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			oe_len <= 0;
		else
			oe_len <= txd_oe ? oe_len + 1 : 0;
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			txd_q <= 1'b1;
			run <= 0;
		end
		else
		begin
			txd_q <= txd;
			run <= txd != txd_q ? 0 : run + 1;
		end
	// a write while busy may be dropped, so only untouched reads are judged
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			cfg_seen <= 1'b0;
		else if (wr && addr == REG_CFG)
			cfg_seen <= 1'b1;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	chk_idle_high: assert property (!txd_oe |-> txd)
		else $error("line low with driver off");
	chk_start_low: assert property ($rose(txd_oe) |-> !txd)
		else $error("character without start bit");
	chk_stop_high: assert property ($fell(txd_oe) |-> $past(txd))
		else $error("character without stop bit");
	chk_char_len: assert property ($fell(txd_oe) |-> oe_len >= CHAR_MIN)
		else $error("character too short");
	chk_bit_time: assert property
		($changed(txd) && $past(txd_oe) && txd_oe |-> run >= BIT_MIN)
		else $error("bit shorter than bit time");
	chk_unmapped_zero: assert property
		(rd && addr > REG_RXINFO |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	chk_cfg_reset: assert property
		(rd && addr == REG_CFG && !cfg_seen |=> rdata == 16'h0008)
		else $error("format reset value wrong");
	chk_gap_limit: assert property
		(rd && addr == REG_GAP |=> rdata <= 16'h03E7)
		else $error("gap above limit");
endmodule

// >>> testbench/panel_model.sv
`timescale 1ns/1ps
module panel_model #(
	parameter int BT = 1736
) (
	// clock
	input  wire logic clk,
	// serial lines
	input  wire logic rx,
	output logic      tx
);
	import host_pkg::*;
	// low 256 words double as the bit area
	logic [15:0] mem [512];
	logic [7:0]  reply_q [$];
	int          nak_stx;
	int          nak_frame;
	logic        even;

	// 8 data, 1 stop at 115200 baud; parity odd unless even is set
	task automatic put(input logic [7:0] b);
		logic [10:0] f;
		f = {1'b1, ~^b ^ even, b, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			tx <= f[i];
			repeat (BT) @(posedge clk);
		end
	endtask

	task automatic get(output logic [7:0] b, output logic ok);
		logic [10:0] f;
		// poll, not an edge: the start bit may already be running
		while (rx !== 1'b0)
			@(posedge clk);
		repeat (BT / 2) @(posedge clk);
		for (int i = 0; i < 11; i++)
		begin
			f[i] = rx;
			if (i < 10)
				repeat (BT) @(posedge clk);
		end
		b = f[8:1];
		ok = !f[0] && f[10] && f[9] == (~^b ^ even);
	endtask

	task automatic take_frame();
		logic [7:0]  f[$];
		logic [7:0]  b, x;
		logic [15:0] a;
		logic        ok, g, esc;
		x = 8'h00;
		ok = 1'b1;
		esc = 1'b0;
		forever
		begin
			get(b, g);
			ok = ok && g;
			x = x ^ b;
			if (esc && b == CH_ETX)
				break;
			if (esc || b != CH_DLE)
				f.push_back(b);
			esc = !esc && b == CH_DLE;
		end
		get(b, g);
		a = {f[2], f[1]};
		ok = ok && g && b == x && f.size() == 4 + f[3];
		if (ok && f[0] == CMD_WORD && f[3] == 8'h02 && a < 16'h0200)
			mem[a] = {f[5], f[4]};
		else if (ok && f[0] == CMD_WORD && f[3] == 8'h04 && a < 16'h01FF && !a[0])
		begin
			mem[a] = {f[5], f[4]};
			mem[a + 1] = {f[7], f[6]};
		end
		else if (ok && f[0] == CMD_BIT && f[3] == 8'h01 && a < 16'h1000)
			mem[a[11:4]][a[3:0]] = f[4][0];
		else
			ok = 1'b0;
		if (ok && nak_frame > 0)
		begin
			nak_frame--;
			ok = 1'b0;
		end
		put(ok ? CH_ACK : CH_NAK);
	endtask

	// touch action: word write to the host, check byte optionally spoilt
	task automatic send_frame(input logic [15:0] a, input logic [15:0] d,
		input logic bad, output logic [7:0] r1, output logic [7:0] r2);
		logic [7:0] s[$];
		logic [7:0] x;
		s = '{CMD_WORD, a[7:0], a[15:8], 8'h02, d[7:0], d[15:8]};
		x = CH_DLE ^ CH_ETX;
		reply_q.delete();
		put(CH_STX);
		for (int i = 0; i < 3000 && reply_q.size() == 0; i++)
			@(posedge clk);
		r1 = reply_q.size() > 0 ? reply_q.pop_front() : 8'hFF;
		foreach (s[i])
			repeat (s[i] == CH_DLE ? 2 : 1)
			begin
				x = x ^ s[i];
				put(s[i]);
			end
		put(CH_DLE);
		put(CH_ETX);
		put(x ^ {7'h00, bad});
		for (int i = 0; i < 3000 && reply_q.size() == 0; i++)
			@(posedge clk);
		r2 = reply_q.size() > 0 ? reply_q.pop_front() : 8'hFF;
	endtask

	initial
	begin : serve
		logic [7:0] b;
		logic       g;
		tx = 1'b1;
		nak_stx = 0;
		nak_frame = 0;
		even = 1'b0;
		foreach (mem[i])
			mem[i] = 16'h0000;
		forever
		begin
			get(b, g);
			if (b != CH_STX)
				reply_q.push_back(b);
			else if (nak_stx > 0)
			begin
				nak_stx--;
				put(CH_NAK);
			end
			else
			begin
				put(CH_ACK);
				take_frame();
			end
		end
	end
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_fail++; \
$display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
	import host_pkg::*;
	logic        clk, nrst, wr, rd, txd, txd_oe, rxd;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, v, w;
	logic [7:0]  b1, b2;
	logic [15:0] exp_mem [512];
	int          n_fail, total_checks, r;

	host_link #(.UNIT_CYC(50), .REPLY_CYC(2000), .BACKOFF_CYC(100),
		.DIV_SHIFT(6))
		host_link_inst (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .txd(txd), .txd_oe(txd_oe), .rxd(rxd));
	panel_model #(.BT(int'(DIV_115200 >> 6)))
		panel_model_inst (.clk(clk), .rx(txd), .tx(rxd));

	initial
	begin
		clk = 1'b0;
		forever
			#2.5 clk = ~clk;
	end

	task automatic end_sim();
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// status is polled in short steps; a hang counts as a failure
	task automatic xfer(input logic [3:0] c, input int a,
		input logic [15:0] d0, input logic [15:0] d1);
		logic ok;
		int   i;
		ok = c[CTRL_BITW] ? a < 4096 : c[CTRL_DBL] ? a < 511 && a % 2 == 0
			: a < 512;
		if (ok && c[CTRL_BITW])
			exp_mem[a / 16][a % 16] = d0[0];
		else if (ok)
			exp_mem[a] = d0;
		if (ok && c[CTRL_DBL])
			exp_mem[a + 1] = d1;
		wr_reg(REG_ADDR, 16'(a));
		wr_reg(REG_DATA0, d0);
		wr_reg(REG_DATA1, d1);
		wr_reg(REG_CTRL, {12'h000, c});
		for (i = 0; i < 400; i++)
		begin
			repeat (50) @(posedge clk);
			rd_reg(REG_STAT, v);
			if (v[ST_BUSY] === 1'b0)
				break;
		end
		if (i == 400)
		begin
			n_fail++;
			end_sim();
		end
		`CHK("stat", {!ok, ok, 1'b0}, v[2:0])
		foreach (exp_mem[k])
			`CHK("mem", exp_mem[k], panel_model_inst.mem[k])
		wr_reg(REG_STAT, 16'h001E);
	endtask

	initial
	begin
		nrst = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		n_fail = 0;
		total_checks = 0;
		foreach (exp_mem[i])
			exp_mem[i] = 16'h0000;
		r = $urandom(50626);
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		rd_reg(REG_CFG, v);
		`CHK("cfg", 16'h0008, v)
		rd_reg(4'hF, v);
		`CHK("unmapped", 16'h0000, v)
		wr_reg(REG_GAP, 16'h03E8);
		rd_reg(REG_GAP, v);
		`CHK("gap", 16'h03E7, v)
		wr_reg(REG_GAP, 16'h0400);
		rd_reg(REG_GAP, v);
		`CHK("gap_wide", 16'h03E7, v)
		wr_reg(REG_GAP, 16'h0001);
		wr_reg(REG_CFG, 16'h000C);
		rd_reg(REG_CFG, v);
		`CHK("cfg", 16'h000C, v)
		xfer(4'h1, 2 * ($urandom % 256), {8'($urandom), 8'h10}, 16'h0000);
		xfer(4'hD, 510, 16'($urandom), 16'h1010);
		xfer(4'h3, $urandom % 4096, 16'h0001, 16'h0000);
		xfer(4'hB, 4095, 16'h0001, 16'h0000);
		panel_model_inst.nak_stx = 1;
		panel_model_inst.nak_frame = 1;
		xfer(4'h1, 511, 16'($urandom), 16'h0000);
		xfer(4'h1, 512, 16'h1234, 16'h0000);
		xfer(4'h5, 3, 16'h1234, 16'h5678);
		wr_reg(REG_CFG, 16'h0054);
		panel_model_inst.even = 1'b1;
		xfer(4'h1, 2 * ($urandom % 256) + 1, 16'($urandom), 16'h0000);
		xfer(4'h3, 4096, 16'h0001, 16'h0000);
		w = {8'($urandom), 8'h10};
		panel_model_inst.send_frame(16'h0005, w, 1'b0, b1, b2);
		`CHK("stx_ack", CH_ACK, b1)
		`CHK("frame_ack", CH_ACK, b2)
		rd_reg(REG_RXADDR, v);
		`CHK("rx_addr", 16'h0005, v)
		rd_reg(REG_RXD0, v);
		`CHK("rx_data", w, v)
		rd_reg(REG_RXINFO, v);
		`CHK("rx_info", 16'h0201, v)
		rd_reg(REG_STAT, v);
		`CHK("rx_new", 1'b1, v[ST_RXNEW])
		wr_reg(REG_STAT, 16'h001E);
		panel_model_inst.send_frame(16'h0006, w, 1'b1, b1, b2);
		`CHK("frame_nak", CH_NAK, b2)
		rd_reg(REG_STAT, v);
		`CHK("rx_bad", 1'b1, v[ST_RXBAD])
		end_sim();
	end
endmodule

bind host_link host_link_props #(.DIV_SHIFT(6)) host_link_props_inst (
	.clk(clk), .nrst(nrst), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
	.txd(txd), .txd_oe(txd_oe));
